//--- hw/hbc_pkg.sv
// constants and types of the host bridge configuration header
`default_nettype none
package hbc_pkg;

  localparam int unsigned CFG_DW_W  = 6;
  localparam int unsigned NUM_ERR   = 4;
  localparam int unsigned TAG_W     = 3;
  localparam int unsigned NUM_TAGS  = 8;
  localparam int unsigned NUM_FLAGS = 3;

  localparam logic [7:0] OFS_STATUS    = 8'h06;
  localparam logic [7:0] OFS_REVISION  = 8'h08;
  localparam logic [7:0] OFS_SUBCLASS  = 8'h0A;
  localparam logic [7:0] OFS_BASECLASS = 8'h0B;
  localparam logic [7:0] OFS_LATENCY   = 8'h0D;
  localparam logic [7:0] OFS_HEADER    = 8'h0E;
  localparam logic [7:0] OFS_CAP_PTR   = 8'h34;

  localparam int unsigned STS_SHIFT   = 16;
  localparam int unsigned STS_HI_LANE = 3;

  localparam int unsigned STS_SYS_ERR = 14;
  localparam int unsigned STS_RMA     = 13;
  localparam int unsigned STS_RTA     = 12;
  localparam int unsigned STS_STA     = 11;
  localparam int unsigned STS_PARITY  = 8;
  localparam int unsigned STS_B2B     = 7;
  localparam int unsigned STS_CLST    = 4;

  localparam logic [15:0] STS_RESET    = 16'h0090;
  localparam logic [15:0] STS_FIXED    = 16'h0090;
  localparam logic [1:0]  SEL_TIMING_VAL = 2'h0;

  localparam logic [7:0] SUBCLASS_VAL  = 8'h00;
  localparam logic [7:0] BASECLASS_VAL = 8'h06;
  localparam logic [7:0] LATENCY_VAL   = 8'h00;
  localparam logic [7:0] HEADER_VAL    = 8'h00;

  localparam int unsigned FLG_SYS_ERR = 0;
  localparam int unsigned FLG_RMA = 1;
  localparam int unsigned FLG_RTA = 2;

  typedef enum logic [1:0] {
    CPL_OK     = 2'h0,
    CPL_MABORT = 2'h1,
    CPL_TABORT = 2'h2,
    CPL_RSVD   = 2'h3
  } hbc_cpl_t;

  typedef enum logic [1:0] {
    MSG_IDLE = 2'b01,
    MSG_SEND = 2'b10
  } hbc_msg_state_t;

endpackage
`default_nettype wire

//--- hw/hbc_flag_if.sv
// carrier for the sticky status flags
`default_nettype none
interface hbc_flag_if;
  logic [hbc_pkg::NUM_FLAGS-1:0] set;
  logic [hbc_pkg::NUM_FLAGS-1:0] clr;
  logic [hbc_pkg::NUM_FLAGS-1:0] flags;
  modport owner (input set, input clr, output flags);
  modport user  (output set, output clr, input flags);
endinterface
`default_nettype wire

//--- hw/hbc_flag_bank.sv
// sticky write-one-to-clear flag bank
`default_nettype none
module hbc_flag_bank (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  hbc_flag_if.owner       fl
);

  typedef struct packed {
    logic [hbc_pkg::NUM_FLAGS-1:0] flags;
  } hbc_bank_state_t;

  hbc_bank_state_t st_reg;
  hbc_bank_state_t st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.flags = (st_reg.flags & ~fl.clr) | fl.set;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fl.flags = st_reg.flags;

endmodule // hbc_flag_bank
`default_nettype wire

//--- hw/hbc_config_header.sv
// configuration header registers of the host bridge function
`default_nettype none
module hbc_config_header #(
  parameter logic [7:0] REVISION_VALUE    = 8'h01,  // arbitrary value
  parameter logic [7:0] CAP_POINTER_VALUE = 8'h40
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         cfg_rd,
  input  wire logic                         cfg_wr,
  input  wire logic [hbc_pkg::CFG_DW_W-1:0] cfg_dword,
  input  wire logic [3:0]                   cfg_be,
  input  wire logic [31:0]                  cfg_wdata,
  output logic                              cfg_claim,
  output logic [31:0]                       cfg_rdata,
  output logic                              cfg_rvalid,
  input  wire logic                         system_error_enable,
  input  wire logic [hbc_pkg::NUM_ERR-1:0]  error_command_mask,
  input  wire logic [hbc_pkg::NUM_ERR-1:0]  err_event,
  output logic                              serr_msg_req,
  output logic [hbc_pkg::NUM_ERR-1:0]       serr_msg_cause,
  input  wire logic                         serr_msg_ack,
  input  wire logic                         hub_req_issue,
  input  wire logic [hbc_pkg::TAG_W-1:0]    hub_req_tag,
  input  wire logic                         cpl_valid,
  input  wire logic [hbc_pkg::TAG_W-1:0]    cpl_tag,
  input  wire hbc_pkg::hbc_cpl_t            cpl_status,
  input  wire logic                         spc_valid,
  input  wire hbc_pkg::hbc_cpl_t            spc_status,
  output logic                              req_outstanding,
  output logic [15:0]                       bridge_error_status
);

  typedef struct packed {
    hbc_pkg::hbc_msg_state_t         msg_state;
    logic [hbc_pkg::NUM_ERR-1:0]     err_pending;
    logic [hbc_pkg::NUM_ERR-1:0]     msg_cause;
    logic [hbc_pkg::NUM_TAGS-1:0]    outstanding;
    logic [31:0]                     rdata;
    logic                            rvalid;
  } hbc_state_t;

  hbc_state_t st_reg;
  hbc_state_t st_next;

  hbc_flag_if flag_bus ();

  hbc_flag_bank u_flags (
    .clk     (clk),
    .sys_rst (sys_rst),
    .fl      (flag_bus.owner)
  );

  logic [15:0] status_word;
  logic        hit_status;
  logic        hit_class;
  logic        hit_timing;
  logic        hit_cap;
  logic        msg_done;
  logic [hbc_pkg::NUM_ERR-1:0] err_enabled;
  logic [hbc_pkg::NUM_FLAGS-1:0] set_vec;
  logic [hbc_pkg::NUM_FLAGS-1:0] clr_vec;

  // place a byte into its lane of a configuration dword
  function automatic logic [31:0] lane_put(input logic [7:0] ofs, input logic [7:0] val);
    logic [31:0] w;
    w = '0;
    w[{ofs[1:0], 3'b000} +: 8] = val;
    return w;
  endfunction

  // true when a dword index matches the dword holding a byte offset
  function automatic logic dword_is(input logic [hbc_pkg::CFG_DW_W-1:0] dw, input logic [7:0] ofs);
    return dw == ofs[7:2];
  endfunction

  // status word assembled from live flags and fixed bits
  always_comb begin
    status_word                   = hbc_pkg::STS_FIXED;
    status_word[hbc_pkg::STS_SYS_ERR] = flag_bus.flags[hbc_pkg::FLG_SYS_ERR];
    status_word[hbc_pkg::STS_RMA] = flag_bus.flags[hbc_pkg::FLG_RMA];
    status_word[hbc_pkg::STS_RTA] = flag_bus.flags[hbc_pkg::FLG_RTA];
    status_word[hbc_pkg::STS_STA] = 1'b0;
    status_word[hbc_pkg::STS_STA-1 -: 2] = hbc_pkg::SEL_TIMING_VAL;
    status_word[hbc_pkg::STS_PARITY] = 1'b0;
  end

  assign bridge_error_status = status_word;

  // address decode of the dwords this block owns
  always_comb begin
    hit_status = dword_is(cfg_dword, hbc_pkg::OFS_STATUS);
    hit_class  = dword_is(cfg_dword, hbc_pkg::OFS_REVISION);
    hit_timing = dword_is(cfg_dword, hbc_pkg::OFS_HEADER);
    hit_cap    = dword_is(cfg_dword, hbc_pkg::OFS_CAP_PTR);
    cfg_claim  = (cfg_rd | cfg_wr) & (hit_status | hit_class | hit_timing | hit_cap);
  end

  // error conditions pass only when individually and globally enabled
  assign err_enabled = system_error_enable ? (err_event & error_command_mask) : '0;

  assign msg_done = (st_reg.msg_state == hbc_pkg::MSG_SEND) & serr_msg_ack;

  // flag set and clear requests
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    set_vec[hbc_pkg::FLG_SYS_ERR] = msg_done;
    if (cpl_valid && st_reg.outstanding[cpl_tag]) begin
      set_vec[hbc_pkg::FLG_RMA] = (cpl_status == hbc_pkg::CPL_MABORT);
      set_vec[hbc_pkg::FLG_RTA] = (cpl_status == hbc_pkg::CPL_TABORT);
    end
    if (spc_valid && (|st_reg.outstanding)) begin
      set_vec[hbc_pkg::FLG_RMA] = set_vec[hbc_pkg::FLG_RMA] | (spc_status == hbc_pkg::CPL_MABORT);
      set_vec[hbc_pkg::FLG_RTA] = set_vec[hbc_pkg::FLG_RTA] | (spc_status == hbc_pkg::CPL_TABORT);
    end
    if (cfg_wr && hit_status && cfg_be[hbc_pkg::STS_HI_LANE]) begin
      clr_vec[hbc_pkg::FLG_SYS_ERR] = cfg_wdata[hbc_pkg::STS_SHIFT + hbc_pkg::STS_SYS_ERR];
      clr_vec[hbc_pkg::FLG_RMA] = cfg_wdata[hbc_pkg::STS_SHIFT + hbc_pkg::STS_RMA];
      clr_vec[hbc_pkg::FLG_RTA] = cfg_wdata[hbc_pkg::STS_SHIFT + hbc_pkg::STS_RTA];
    end
  end

  assign flag_bus.set = set_vec;
  assign flag_bus.clr = clr_vec;

  // next state of message engine, request tracker and read port
  always_comb begin
    st_next        = st_reg;
    st_next.rvalid = cfg_rd;
    st_next.rdata  = '0;

    if (cfg_rd) begin
      if (hit_status) begin
        st_next.rdata = {status_word, 16'h0000};
      end else if (hit_class) begin
        st_next.rdata = lane_put(hbc_pkg::OFS_REVISION, REVISION_VALUE)
                      | lane_put(hbc_pkg::OFS_SUBCLASS, hbc_pkg::SUBCLASS_VAL)
                      | lane_put(hbc_pkg::OFS_BASECLASS, hbc_pkg::BASECLASS_VAL);
      end else if (hit_timing) begin
        st_next.rdata = lane_put(hbc_pkg::OFS_LATENCY, hbc_pkg::LATENCY_VAL)
                      | lane_put(hbc_pkg::OFS_HEADER, hbc_pkg::HEADER_VAL);
      end else if (hit_cap) begin
        st_next.rdata = lane_put(hbc_pkg::OFS_CAP_PTR, CAP_POINTER_VALUE);
      end
    end

    // request tracker: completion retires a tag before a new issue reuses it
    if (cpl_valid) begin
      st_next.outstanding[cpl_tag] = 1'b0;
    end
    if (hub_req_issue) begin
      st_next.outstanding[hub_req_tag] = 1'b1;
    end

    // error message engine
    if (!system_error_enable) begin
      st_next.err_pending = '0;
    end else begin
      st_next.err_pending = st_reg.err_pending | err_enabled;
    end

    unique case (st_reg.msg_state)
      hbc_pkg::MSG_IDLE: begin
        if (system_error_enable && (|(st_reg.err_pending | err_enabled))) begin
          st_next.msg_state   = hbc_pkg::MSG_SEND;
          st_next.msg_cause   = st_reg.err_pending | err_enabled;
          st_next.err_pending = '0;
        end
      end
      hbc_pkg::MSG_SEND: begin
        if (serr_msg_ack) begin
          st_next.msg_state = hbc_pkg::MSG_IDLE;
          st_next.msg_cause = '0;
        end
      end
      default: begin
        st_next.msg_state = hbc_pkg::MSG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg.msg_state   <= hbc_pkg::MSG_IDLE;
      st_reg.err_pending <= '0;
      st_reg.msg_cause   <= '0;
      st_reg.outstanding <= '0;
      st_reg.rdata       <= '0;
      st_reg.rvalid      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serr_msg_req    = (st_reg.msg_state == hbc_pkg::MSG_SEND);
  assign serr_msg_cause  = st_reg.msg_cause;
  assign req_outstanding = |st_reg.outstanding;
  assign cfg_rdata       = st_reg.rdata;
  assign cfg_rvalid      = st_reg.rvalid;

endmodule // hbc_config_header
`default_nettype wire

//--- verif/hbc_config_header_props.sv
// assertions on the host bridge configuration header ports
`default_nettype none
module hbc_config_header_props (
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         cfg_rd,
  input wire logic                         cfg_wr,
  input wire logic [hbc_pkg::CFG_DW_W-1:0] cfg_dword,
  input wire logic [3:0]                   cfg_be,
  input wire logic [31:0]                  cfg_wdata,
  input wire logic [31:0]                  cfg_rdata,
  input wire logic                         cfg_rvalid,
  input wire logic                         system_error_enable,
  input wire logic [hbc_pkg::NUM_ERR-1:0]  error_command_mask,
  input wire logic [hbc_pkg::NUM_ERR-1:0]  err_event,
  input wire logic                         serr_msg_req,
  input wire logic                         serr_msg_ack,
  input wire logic [15:0]                  bridge_error_status
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic clr14;
  logic acked;
  logic msg_trig;
  assign clr14 = cfg_wr && cfg_dword == 6'h01 && cfg_be[3] && cfg_wdata[30];
  assign acked = serr_msg_req && serr_msg_ack;
  assign msg_trig = system_error_enable && (|(err_event & error_command_mask)) && !serr_msg_req;
  chk_fixed_bits: assert property ((bridge_error_status & 16'h8FFF) == 16'h0090)
    else $error("fixed status bits wrong");
  chk_class_codes: assert property (cfg_rd && cfg_dword == 6'h02 |=> cfg_rvalid && cfg_rdata[31:8] == 24'h060000)
    else $error("class codes wrong");
  chk_unused_dword: assert property (cfg_rd && cfg_dword == 6'h03 |=> cfg_rdata == 32'h0)
    else $error("latency or header not zero");
  chk_syserr_clear: assert property (clr14 && !acked |=> !bridge_error_status[14])
    else $error("system error flag not cleared");
  chk_syserr_set: assert property (acked |=> bridge_error_status[14])
    else $error("system error flag not set");
  chk_syserr_cause: assert property ($rose(bridge_error_status[14]) |-> $past(acked))
    else $error("system error flag set without message");
  chk_msg_start: assert property (msg_trig |=> serr_msg_req)
    else $error("enabled error sent no message");
  chk_msg_gated: assert property ($rose(serr_msg_req) |-> $past(system_error_enable))
    else $error("message sent while disabled");
  chk_msg_hold: assert property (serr_msg_req |=> serr_msg_req == !$past(serr_msg_ack))
    else $error("message request not held to ack");
  cover property (acked && clr14);
  cover property ($fell(bridge_error_status[13]));
  cover property (cfg_rd && cfg_dword == 6'h0D);
  cover property ($rose(bridge_error_status[12]));
endmodule // hbc_config_header_props
bind hbc_config_header hbc_config_header_props u_props (.clk(clk), .sys_rst(sys_rst), .cfg_rd(cfg_rd),
  .cfg_wr(cfg_wr), .cfg_dword(cfg_dword), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .cfg_rvalid(cfg_rvalid), .system_error_enable(system_error_enable), .error_command_mask(error_command_mask),
  .err_event(err_event), .serr_msg_req(serr_msg_req), .serr_msg_ack(serr_msg_ack),
  .bridge_error_status(bridge_error_status));
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench of the host bridge configuration header
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV = 8'h5A;  // arbitrary value
  localparam logic [7:0] CAP = 8'hA4;
  logic clk = 1'b0, sys_rst = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0, serr_msg_ack = 1'b0, system_error_enable = 1'b0;
  logic hub_req_issue = 1'b0, cpl_valid = 1'b0, spc_valid = 1'b0, cfg_claim, cfg_rvalid, serr_msg_req, req_outstanding;
  logic [5:0] cfg_dword = 6'h00;
  logic [3:0] cfg_be = 4'h0, error_command_mask = 4'h0, err_event = 4'h0, serr_msg_cause;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [2:0] hub_req_tag = 3'h0, cpl_tag = 3'h0;
  logic [15:0] bridge_error_status;
  hbc_pkg::hbc_cpl_t cpl_status = hbc_pkg::CPL_OK, spc_status = hbc_pkg::CPL_OK;
  int error_cnt = 0, checked = 0;
  logic [5:0] dws[5] = '{6'h01, 6'h02, 6'h03, 6'h0D, 6'h05};
  logic [31:0] exps[5] = '{32'h0090_0000, {24'h06_0000, REV}, 32'h0, {24'h0, CAP}, 32'h0};
  hbc_config_header #(.REVISION_VALUE(REV), .CAP_POINTER_VALUE(CAP)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_dword(cfg_dword), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .system_error_enable(system_error_enable),
    .error_command_mask(error_command_mask), .err_event(err_event), .serr_msg_req(serr_msg_req),
    .serr_msg_cause(serr_msg_cause), .serr_msg_ack(serr_msg_ack), .hub_req_issue(hub_req_issue),
    .hub_req_tag(hub_req_tag), .cpl_valid(cpl_valid), .cpl_tag(cpl_tag), .cpl_status(cpl_status),
    .spc_valid(spc_valid), .spc_status(spc_status), .req_outstanding(req_outstanding),
    .bridge_error_status(bridge_error_status));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
    @(negedge clk);
    cfg_rd = 1'b1;
    cfg_dword = dw;
    #1;
    check({31'h0, cfg_claim}, {31'h0, (dw inside {6'h01, 6'h02, 6'h03, 6'h0D})});
    @(negedge clk);
    cfg_rd = 1'b0;
    check({31'h0, cfg_rvalid}, 32'h1);
    check(cfg_rdata, exp);
  endtask
  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_dword = dw;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  task automatic evt(input logic [3:0] e);
    @(negedge clk);
    err_event = e;
    @(negedge clk);
    err_event = 4'h0;
  endtask
  task automatic hub(input logic iss, input logic cv, input logic sv, input logic [2:0] tg, input hbc_pkg::hbc_cpl_t st);
    @(negedge clk);
    {hub_req_issue, cpl_valid, spc_valid} = {iss, cv, sv};
    {hub_req_tag, cpl_tag, cpl_status, spc_status} = {tg, tg, st, st};
    @(negedge clk);
    {hub_req_issue, cpl_valid, spc_valid} = 3'h0;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) rd(dws[i], exps[i]);
    for (int i = 0; i < 5; i++) wr(dws[i], 4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++) rd(dws[i], exps[i]);
    error_command_mask = 4'h3;
    evt(4'h1);
    check({31'h0, serr_msg_req}, 32'h0);
    system_error_enable = 1'b1;
    evt(4'h4);
    check({31'h0, serr_msg_req}, 32'h0);
    evt(4'h2);
    check({28'h0, serr_msg_cause}, 32'h2);
    serr_msg_ack = 1'b1;
    @(negedge clk);
    serr_msg_ack = 1'b0;
    check({16'h0, bridge_error_status}, 32'h4090);
    wr(6'h01, 4'h8, 32'h0);
    rd(6'h01, 32'h4090_0000);
    wr(6'h01, 4'h8, 32'h4000_0000);
    check({16'h0, bridge_error_status}, 32'h0090);
    evt(4'h1);
    fork
      wr(6'h01, 4'h8, 32'h4000_0000);
      begin
        @(negedge clk);
        serr_msg_ack = 1'b1;
        @(negedge clk);
        serr_msg_ack = 1'b0;
      end
    join
    check({16'h0, bridge_error_status}, 32'h4090);
    hub(1'b1, 1'b0, 1'b0, 3'h2, hbc_pkg::CPL_OK);
    check({31'h0, req_outstanding}, 32'h1);
    hub(1'b0, 1'b1, 1'b0, 3'h2, hbc_pkg::CPL_MABORT);
    check({16'h0, bridge_error_status}, 32'h6090);
    check({31'h0, req_outstanding}, 32'h0);
    hub(1'b0, 1'b1, 1'b0, 3'h5, hbc_pkg::CPL_TABORT);
    hub(1'b0, 1'b0, 1'b1, 3'h0, hbc_pkg::CPL_TABORT);
    check({16'h0, bridge_error_status}, 32'h6090);
    hub(1'b1, 1'b0, 1'b0, 3'h5, hbc_pkg::CPL_OK);
    hub(1'b0, 1'b0, 1'b1, 3'h0, hbc_pkg::CPL_TABORT);
    check({16'h0, bridge_error_status}, 32'h7090);
    wr(6'h01, 4'h8, 32'h7000_0000);
    rd(6'h01, 32'h0090_0000);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
